// File: design/spindle_test_mode.sv
// Test pin decode, observation stepping, braking and power states of the spindle combo.
//
// Summary of operation
// RULE1: Hall select zero: hall output follows filtered back-EMF crossings, in phase.
// RULE2: Hall select one: one hall period per electrical cycle, half high.
// RULE3: Brake command retracts the actuator first, then turns on all low-side drivers.
// RULE4: Test pin high, tri-state pin low selects continuity mapping mode.
// RULE5: Mapping routes read/write and load to data, clocks to hall, undervoltages to reset.
// RULE6: Test pin and tri-state pin both high select observation mode.
// RULE7: Each serial clock pulse from the tester advances the observation step.
// RULE8: Steps one to seven show FLL increment, mask, delay, divided clock, comparator, predrivers.
// RULE9: Step four shows reference clock over 16 or 32, per prescale bit.
// RULE10: Analog observation select follows the same step count as the digital one.
// RULE11: Tri-state pin alone high releases hall, reset and serial data outputs.
// RULE12: Both test pins low means no test mode and normal operation.
// RULE13: Power is ready with both enabled, idle with spindle only, sleep with none.
// RULE14: Spindle off with VCM on is invalid: low gain and automatic park.
// RULE15: Two inputs sharing a mapped output appear as their exclusive-OR.
// RULE16: Step count starts at one on observation entry and wraps seven to one.
`default_nettype none
module spindle_test_mode
   import spindle_test_pkg::*;
#(
   parameter int FILTER_CYCLES       = HALL_FILTER_CYCLES,
   parameter int HALF_CYCLE_CROSSING = HALL_HALF_CYCLE_CROSSINGS
) (
   input  wire logic              i_clock,
   input  wire logic              i_sys_rst,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wr_data,
   input  wire logic              i_wr_strobe,
   input  wire logic              i_rd_strobe,
   output logic      [DATA_W-1:0] o_rd_data,
   input  wire logic              i_test_select,
   input  wire logic              i_tristate_select,
   input  wire logic              i_read_write,
   input  wire logic              i_serial_load,
   input  wire logic              i_serial_clock,
   input  wire logic              i_refclk_pin_level,
   input  wire logic              i_undervoltage_in_a,
   input  wire logic              i_undervoltage_in_b,
   input  wire logic              i_serial_data_out,
   input  wire logic              i_serial_data_drive,
   input  wire logic              i_reset_request,
   input  wire logic              i_bemf_raw,
   input  wire logic              i_fll_increment,
   input  wire logic              i_spindle_mask,
   input  wire logic              i_spindle_delay,
   input  wire logic              i_vcm_predriver_a,
   input  wire logic              i_vcm_predriver_f,
   input  wire logic              i_retract_done,
   output logic                   o_serial_data,
   output logic                   o_serial_data_oe_n,
   output logic                   o_hall_out,
   output logic                   o_hall_oe_n,
   output logic                   o_reset_out,
   output logic                   o_reset_oe_n,
   output logic                   o_digital_observe_out,
   output logic      [STEP_W-1:0] o_analog_observe_out,
   output logic      [2:0]        o_low_side_on,
   output logic                   o_retract_req,
   output logic                   o_park_req,
   output logic                   o_spindle_low_gain,
   output logic      [1:0]        o_power_state
);

   logic [DATA_W-1:0] ctrl_reg;
   test_mode_t        mode_reg;
   test_mode_t        prev_mode_reg;
   logic [STEP_W-1:0] step_reg;
   logic              sclk_d_reg;
   logic [DIV_W-1:0]  div_reg;
   brake_state_t      brake_state_reg;
   brake_state_t      brake_state_next;
   power_state_t      power_state;
   logic              hall_level;
   logic              sclk_pulse;
   logic              observe_entry;
   logic              refdiv_level;
   logic              observe_bit;
   logic              map_sdio_xor;
   logic              map_hall_xor;
   logic              map_reset_xor;
   logic [DATA_W-1:0] status_word;

   hall_synth #(
      .FILTER_CYCLES       (FILTER_CYCLES),
      .HALF_CYCLE_CROSSING (HALF_CYCLE_CROSSING)
   ) u_hall (
      .i_clock       (i_clock),
      .i_sys_rst     (i_sys_rst),
      .i_bemf_raw    (i_bemf_raw),
      .i_hall_select (ctrl_reg[CTRL_HALL_SEL_BIT]),
      .o_hall_level  (hall_level)
   );

   // Register port: control written by software, status reads back block state.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         ctrl_reg <= CTRL_RESET;
      end else if (i_wr_strobe && (i_addr == CTRL_OFFSET)) begin
         ctrl_reg <= i_wr_data & CTRL_USED_MASK;
      end
   end

   assign status_word = {brake_state_reg != BRK_OFF, step_reg, mode_reg, power_state};

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_rd_data <= DATA_ZERO;
      end else if (i_rd_strobe && (i_addr == CTRL_OFFSET)) begin
         o_rd_data <= ctrl_reg;
      end else if (i_rd_strobe && (i_addr == STATUS_OFFSET)) begin
         o_rd_data <= status_word;
      end else begin
         o_rd_data <= DATA_ZERO;
      end
   end

   // Test pin decode; the pins are taken as synchronous and registered once.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         mode_reg      <= MODE_NORMAL;
         prev_mode_reg <= MODE_NORMAL;
      end else begin
         mode_reg      <= test_mode_t'({i_test_select, i_tristate_select}); // see RULE4 see RULE6 see RULE12
         prev_mode_reg <= mode_reg;
      end
   end

   // Observation stepping on rising serial clock edges.
   assign sclk_pulse    = i_serial_clock && !sclk_d_reg;
   assign observe_entry = (mode_reg == MODE_OBSERVE) && (prev_mode_reg != MODE_OBSERVE);

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         sclk_d_reg <= 1'b0;
      end else begin
         sclk_d_reg <= i_serial_clock;
      end
   end

   // Entry wins over a coincident clock pulse so the tester always starts from step one.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         step_reg <= STEP_FLL;
      end else if (observe_entry) begin
         step_reg <= STEP_FLL; // see RULE16
      end else if ((mode_reg == MODE_OBSERVE) && sclk_pulse) begin
         if (step_reg == STEP_VCM_F) begin
            step_reg <= STEP_FLL; // see RULE16
         end else begin
            step_reg <= step_reg + STEP_ONE; // see RULE7
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + DIV_ONE;
      end
   end

   assign refdiv_level = ctrl_reg[CTRL_PRESCALE_BIT] ? div_reg[DIV32_BIT] : div_reg[DIV16_BIT]; // see RULE9

   always_comb begin
      case (step_reg)
         STEP_FLL:    observe_bit = i_fll_increment; // see RULE8
         STEP_MASK:   observe_bit = i_spindle_mask;
         STEP_DELAY:  observe_bit = i_spindle_delay;
         STEP_REFDIV: observe_bit = refdiv_level;
         STEP_BEMF:   observe_bit = i_bemf_raw;
         STEP_VCM_A:  observe_bit = i_vcm_predriver_a;
         STEP_VCM_F:  observe_bit = i_vcm_predriver_f;
         default:     observe_bit = 1'b0;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_digital_observe_out <= 1'b0;
         o_analog_observe_out  <= STEP_ZERO;
      end else if (mode_reg == MODE_OBSERVE) begin
         o_digital_observe_out <= observe_bit;
         o_analog_observe_out  <= step_reg; // see RULE10
      end else begin
         o_digital_observe_out <= 1'b0;
         o_analog_observe_out  <= STEP_ZERO;
      end
   end

   // Pin mapping: paired inputs are XORed so a single open joint still shows.
   assign map_sdio_xor  = i_read_write ^ i_serial_load; // see RULE15
   assign map_hall_xor  = i_serial_clock ^ i_refclk_pin_level; // see RULE15
   assign map_reset_xor = i_undervoltage_in_a ^ i_undervoltage_in_b; // see RULE15

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_serial_data      <= 1'b0;
         o_serial_data_oe_n <= 1'b1;
         o_hall_out         <= 1'b0;
         o_hall_oe_n        <= 1'b0;
         o_reset_out        <= 1'b0;
         o_reset_oe_n       <= 1'b0;
      end else begin
         case (mode_reg)
            MODE_MAPPING: begin
               o_serial_data      <= map_sdio_xor; // see RULE5
               o_serial_data_oe_n <= 1'b0;
               o_hall_out         <= map_hall_xor;
               o_hall_oe_n        <= 1'b0;
               o_reset_out        <= map_reset_xor;
               o_reset_oe_n       <= 1'b0;
            end
            MODE_TRISTATE: begin
               o_serial_data      <= 1'b0; // see RULE11
               o_serial_data_oe_n <= 1'b1;
               o_hall_out         <= 1'b0;
               o_hall_oe_n        <= 1'b1;
               o_reset_out        <= 1'b0;
               o_reset_oe_n       <= 1'b1;
            end
            default: begin
               o_serial_data      <= i_serial_data_out; // see RULE12
               o_serial_data_oe_n <= !i_serial_data_drive;
               o_hall_out         <= hall_level;
               o_hall_oe_n        <= 1'b0;
               o_reset_out        <= i_reset_request;
               o_reset_oe_n       <= 1'b0;
            end
         endcase
      end
   end

   // Braking: the heads must be off the platter before the spindle is shorted.
   always_comb begin
      case (brake_state_reg)
         BRK_OFF:     brake_state_next = ctrl_reg[CTRL_BRAKE_BIT] ? BRK_RETRACT : BRK_OFF;
         BRK_RETRACT: brake_state_next = i_retract_done ? BRK_HOLD : BRK_RETRACT; // see RULE3
         BRK_HOLD:    brake_state_next = ctrl_reg[CTRL_BRAKE_BIT] ? BRK_HOLD : BRK_OFF;
         default:     brake_state_next = BRK_OFF;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         brake_state_reg <= BRK_OFF;
      end else begin
         brake_state_reg <= brake_state_next;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_low_side_on <= LOW_SIDE_OFF;
         o_retract_req <= 1'b0;
      end else begin
         o_low_side_on <= (brake_state_reg == BRK_HOLD) ? LOW_SIDE_ALL : LOW_SIDE_OFF; // see RULE3
         o_retract_req <= (brake_state_reg == BRK_RETRACT);
      end
   end

   // Power state from the two enables.
   assign power_state = power_state_t'({ctrl_reg[CTRL_VCM_EN_BIT] ^ ctrl_reg[CTRL_SPIN_EN_BIT] ?
                        ctrl_reg[CTRL_VCM_EN_BIT] : ctrl_reg[CTRL_SPIN_EN_BIT], ctrl_reg[CTRL_SPIN_EN_BIT]});

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_power_state      <= PWR_SLEEP;
         o_park_req         <= 1'b0;
         o_spindle_low_gain <= 1'b0;
      end else begin
         o_power_state      <= power_state; // see RULE13
         o_park_req         <= (power_state == PWR_INVALID); // see RULE14
         o_spindle_low_gain <= (power_state == PWR_INVALID);
      end
   end

   a_mapping_data_xor: // see RULE5
   assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (mode_reg == MODE_MAPPING) |=> (o_serial_data == $past(map_sdio_xor)) && !o_serial_data_oe_n
         && (o_reset_out == $past(map_reset_xor)) && (o_hall_out == $past(map_hall_xor)))
      else $error("mapping outputs do not carry the XOR of their inputs");

   a_tristate_released: // see RULE11
   assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (i_test_select == 1'b0) && i_tristate_select ##1 (mode_reg == MODE_TRISTATE)
         |=> o_hall_oe_n && o_reset_oe_n && o_serial_data_oe_n)
      else $error("tri-state mode left a digital output driven");

   a_observe_entry_step: // see RULE16
   assert property (@(posedge i_clock) disable iff (i_sys_rst)
      observe_entry |=> (step_reg == STEP_FLL))
      else $error("observation entry did not restart at step one");

   a_step_wrap_seven: // see RULE16
   assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (mode_reg == MODE_OBSERVE) && !observe_entry && sclk_pulse && (step_reg == STEP_VCM_F)
         |=> (step_reg == STEP_FLL))
      else $error("step count did not wrap from seven to one");

   a_step_advance_pulse: // see RULE7
   assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (mode_reg == MODE_OBSERVE) && !observe_entry && sclk_pulse && (step_reg != STEP_VCM_F)
         |=> (step_reg == $past(step_reg) + STEP_ONE))
      else $error("serial clock pulse did not advance the step");

   a_analog_lockstep: // see RULE10
   assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (mode_reg == MODE_OBSERVE) |=> (o_analog_observe_out == $past(step_reg)))
      else $error("analog select out of step with digital select");

   a_refdiv_step_four: // see RULE9
   assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (mode_reg == MODE_OBSERVE) && (step_reg == STEP_REFDIV) |=> (o_digital_observe_out == $past(refdiv_level)))
      else $error("step four does not show the divided reference clock");

   a_brake_after_retract: // see RULE3
   assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (brake_state_reg == BRK_RETRACT) && i_retract_done
         |=> ##1 (o_low_side_on == LOW_SIDE_ALL) && !o_retract_req)
      else $error("low-side drivers not on after retract completed");

   a_brake_waits_retract: // see RULE3
   assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (brake_state_reg == BRK_RETRACT) |=> o_retract_req && (o_low_side_on == LOW_SIDE_OFF))
      else $error("low-side drivers on before retract finished");

   a_invalid_parks: // see RULE14
   assert property (@(posedge i_clock) disable iff (i_sys_rst)
      !ctrl_reg[CTRL_SPIN_EN_BIT] && ctrl_reg[CTRL_VCM_EN_BIT]
         |=> o_park_req && o_spindle_low_gain && (o_power_state == PWR_INVALID))
      else $error("invalid enable pair did not park with low gain");

   a_power_ready_idle: // see RULE13
   assert property (@(posedge i_clock) disable iff (i_sys_rst)
      ctrl_reg[CTRL_SPIN_EN_BIT] |=> (o_power_state == ($past(ctrl_reg[CTRL_VCM_EN_BIT]) ? PWR_READY : PWR_IDLE))
         && !o_park_req)
      else $error("power state wrong with spindle enabled");

endmodule : spindle_test_mode
`default_nettype wire

// File: design/spindle_test_pkg.sv
// Shared constants and types for the spindle combo test and mode logic.
`default_nettype none
package spindle_test_pkg;

   localparam int CLOCK_FREQ_HZ   = 10_000_000;
   localparam int CLOCK_PERIOD_NS = 1_000_000_000 / CLOCK_FREQ_HZ;

   // Least time a comparator level must hold before it counts as a crossing.
   localparam int HALL_FILTER_NS     = 500;
   localparam int HALL_FILTER_CYCLES = (HALL_FILTER_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int HALL_HALF_CYCLE_CROSSINGS = 3;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 4'h0;
   localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h1;

   localparam int CTRL_HALL_SEL_BIT = 0;
   localparam int CTRL_PRESCALE_BIT = 1;
   localparam int CTRL_BRAKE_BIT    = 2;
   localparam int CTRL_SPIN_EN_BIT  = 3;
   localparam int CTRL_VCM_EN_BIT   = 4;
   localparam logic [DATA_W-1:0] CTRL_RESET     = 8'h00;
   localparam logic [DATA_W-1:0] CTRL_USED_MASK = 8'h1F;
   localparam logic [DATA_W-1:0] DATA_ZERO      = 8'h00;

   localparam int STEP_W = 3;
   localparam logic [STEP_W-1:0] STEP_ZERO     = 3'h0;
   localparam logic [STEP_W-1:0] STEP_FLL      = 3'h1;
   localparam logic [STEP_W-1:0] STEP_MASK     = 3'h2;
   localparam logic [STEP_W-1:0] STEP_DELAY    = 3'h3;
   localparam logic [STEP_W-1:0] STEP_REFDIV   = 3'h4;
   localparam logic [STEP_W-1:0] STEP_BEMF     = 3'h5;
   localparam logic [STEP_W-1:0] STEP_VCM_A    = 3'h6;
   localparam logic [STEP_W-1:0] STEP_VCM_F    = 3'h7;
   localparam logic [STEP_W-1:0] STEP_ONE      = 3'h1;

   localparam int DIV_W      = 5;
   localparam int DIV16_BIT  = 3;
   localparam int DIV32_BIT  = 4;
   localparam logic [DIV_W-1:0] DIV_ONE = 5'h01;

   localparam logic [2:0] LOW_SIDE_ALL = 3'h7;
   localparam logic [2:0] LOW_SIDE_OFF = 3'h0;

   typedef enum logic [1:0] {
      MODE_NORMAL   = 2'b00,
      MODE_TRISTATE = 2'b01,
      MODE_MAPPING  = 2'b10,
      MODE_OBSERVE  = 2'b11
   } test_mode_t;

   typedef enum logic [1:0] {
      PWR_SLEEP   = 2'b00,
      PWR_IDLE    = 2'b01,
      PWR_INVALID = 2'b10,
      PWR_READY   = 2'b11
   } power_state_t;

   typedef enum logic [1:0] {
      BRK_OFF     = 2'b00,
      BRK_RETRACT = 2'b01,
      BRK_HOLD    = 2'b10
   } brake_state_t;

endpackage : spindle_test_pkg
`default_nettype wire

// File: design/hall_synth.sv
// Synthesized hall waveform from the filtered back-EMF comparator.
`default_nettype none
module hall_synth
   import spindle_test_pkg::*;
#(
   parameter int FILTER_CYCLES       = HALL_FILTER_CYCLES,
   parameter int HALF_CYCLE_CROSSING = HALL_HALF_CYCLE_CROSSINGS
) (
   input  wire logic i_clock,
   input  wire logic i_sys_rst,
   input  wire logic i_bemf_raw,
   input  wire logic i_hall_select,
   output logic      o_hall_level
);

   logic [7:0] filt_cnt_reg;
   logic       filt_reg;
   logic [3:0] cross_cnt_reg;
   logic       ecycle_reg;
   logic       crossing;

   // A level must hold for the whole filter time; shorter glitches never reach the pin.
   assign crossing = (i_bemf_raw != filt_reg) && (filt_cnt_reg == 8'(FILTER_CYCLES - 1));

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         filt_cnt_reg <= 8'h00;
         filt_reg     <= 1'b0;
      end else if (crossing) begin // see RULE1
         filt_cnt_reg <= 8'h00;
         filt_reg     <= i_bemf_raw;
      end else if (i_bemf_raw != filt_reg) begin
         filt_cnt_reg <= filt_cnt_reg + 8'h01;
      end else begin
         filt_cnt_reg <= 8'h00;
      end
   end

   // Equal spacing of crossings is assumed; the duty cycle is as even as the motor is.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         cross_cnt_reg <= 4'h0;
         ecycle_reg    <= 1'b0;
      end else if (crossing) begin
         if (cross_cnt_reg == 4'(HALF_CYCLE_CROSSING - 1)) begin // see RULE2
            cross_cnt_reg <= 4'h0;
            ecycle_reg    <= ~ecycle_reg;
         end else begin
            cross_cnt_reg <= cross_cnt_reg + 4'h1;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_hall_level <= 1'b0;
      end else begin
         o_hall_level <= i_hall_select ? ecycle_reg : filt_reg; // see RULE1 see RULE2
      end
   end

endmodule : hall_synth
`default_nettype wire

// File: testbench/tester_model.sv
// Board tester model that pulses the serial clock and answers actuator retract.
`default_nettype none
module tester_model (
   input  wire logic i_clock,
   input  wire logic i_go,
   input  wire logic i_slow,
   input  wire logic i_retract_req,
   output logic      o_serial_clock,
   output logic      o_retract_done
);
   timeunit 1ns;
   timeprecision 1ns;
   int unsigned hi_cnt   = 0;
   int unsigned wait_cnt = 0;
   // A pulse stays high two cycles so that a sampled edge detector cannot miss it.
   always @(posedge i_clock) begin
      hi_cnt <= i_go ? 2 : (hi_cnt > 0 ? hi_cnt - 1 : 0);
      o_serial_clock <= i_go || hi_cnt > 1;
   end
   // The slow answer stands for a heavy actuator that takes longer to park.
   always @(posedge i_clock) begin
      wait_cnt <= i_retract_req ? wait_cnt + 1 : 0;
      o_retract_done <= i_retract_req && wait_cnt >= (i_slow ? 6 : 1);
   end
endmodule : tester_model
`default_nettype wire

// File: testbench/spindle_combo_test_and_mode_logic_bench.sv
// Self-checking bench of the spindle test and mode logic.
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_errors++; \
   $display("wrong value %s exp %h got %h", nm, ex, got); end end
module spindle_combo_test_and_mode_logic_bench
   import spindle_test_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clock = 0, i_sys_rst = 1, i_wr_strobe = 0, i_rd_strobe = 0, rd_d = 0, go = 0, slow = 0, sclk_b = 0;
   logic [ADDR_W-1:0] i_addr = 0;
   logic [DATA_W-1:0] i_wr_data = 0, o_rd_data, e;
   logic i_test_select = 0, i_tristate_select = 0, i_read_write = 0, i_serial_load = 0;
   logic i_refclk_pin_level = 0, i_undervoltage_in_a = 0, i_undervoltage_in_b = 0, i_serial_data_out = 0;
   logic i_serial_data_drive = 0, i_reset_request = 0, i_bemf_raw = 0, i_fll_increment = 0, i_spindle_mask = 0;
   logic i_spindle_delay = 0, i_vcm_predriver_a = 0, i_vcm_predriver_f = 0, sclk_m, i_retract_done;
   logic o_serial_data, o_serial_data_oe_n, o_hall_out, o_hall_oe_n, o_reset_out, o_reset_oe_n;
   logic o_digital_observe_out, o_retract_req, o_park_req, o_spindle_low_gain;
   logic [2:0] o_analog_observe_out, o_low_side_on;
   logic [1:0] o_power_state;
   wire i_serial_clock = sclk_m ^ sclk_b;
   int n_errors = 0, n_tests = 0, cyc_cnt = 0, seed = 32'h87aa_c316;
   logic [DATA_W-1:0] exp_q[$];

   spindle_test_mode #(.FILTER_CYCLES(2), .HALF_CYCLE_CROSSING(3)) u_dut (.i_clock, .i_sys_rst, .i_addr,
      .i_wr_data, .i_wr_strobe, .i_rd_strobe, .o_rd_data, .i_test_select, .i_tristate_select, .i_read_write,
      .i_serial_load, .i_serial_clock, .i_refclk_pin_level, .i_undervoltage_in_a, .i_undervoltage_in_b,
      .i_serial_data_out, .i_serial_data_drive, .i_reset_request, .i_bemf_raw, .i_fll_increment,
      .i_spindle_mask, .i_spindle_delay, .i_vcm_predriver_a, .i_vcm_predriver_f, .i_retract_done,
      .o_serial_data, .o_serial_data_oe_n, .o_hall_out, .o_hall_oe_n, .o_reset_out, .o_reset_oe_n,
      .o_digital_observe_out, .o_analog_observe_out, .o_low_side_on, .o_retract_req, .o_park_req,
      .o_spindle_low_gain, .o_power_state);
   tester_model u_tester (.i_clock(i_clock), .i_go(go), .i_slow(slow), .i_retract_req(o_retract_req),
      .o_serial_clock(sclk_m), .o_retract_done(i_retract_done));

   initial forever #50 i_clock = ~i_clock;

   // Read data stand only in the cycle after the strobe, so that cycle alone is compared.
   always @(posedge i_clock) begin
      rd_d <= i_rd_strobe;
      cyc_cnt++;
      if (rd_d) begin
         e = exp_q.pop_front();
         `CHK("read data", e, o_rd_data)
      end
      if (cyc_cnt == 20000) begin
         n_errors++;
         close_out();
      end
   end

   task automatic close_out();
      $display("tests %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clock);
   endtask : cyc

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge i_clock);
      i_addr <= a;
      i_wr_data <= d;
      i_wr_strobe <= 1'b1;
      @(posedge i_clock);
      i_wr_strobe <= 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge i_clock);
      exp_q.push_back(d);
      i_addr <= a;
      i_rd_strobe <= 1'b1;
      @(posedge i_clock);
      i_rd_strobe <= 1'b0;
   endtask : rd

   task automatic pins(input logic t, input logic s);
      @(posedge i_clock);
      i_test_select <= t;
      i_tristate_select <= s;
      cyc(3);
   endtask : pins

   // Counts cycles between two changes of the observed bit, capped so a stuck bit cannot hang.
   task automatic gap(output int n);
      logic l;
      @(negedge i_clock);
      repeat (2) begin
         l = o_digital_observe_out;
         n = 0;
         while (o_digital_observe_out === l && n < 40) begin
            @(negedge i_clock);
            n++;
         end
      end
   endtask : gap

   initial begin
      logic [31:0] v;
      logic [1:0] pe;
      logic [2:0] s;
      logic ob;
      int n;
      repeat (8) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      rd(CTRL_OFFSET, CTRL_RESET);
      wr(CTRL_OFFSET, 8'hE3);
      rd(CTRL_OFFSET, 8'h03);
      rd(4'hF, DATA_ZERO);
      for (int i = 0; i < 4; i++) begin
         wr(CTRL_OFFSET, DATA_W'(i) << 3);
         pe = i[1] ? (i[0] ? PWR_READY : PWR_INVALID) : (i[0] ? PWR_IDLE : PWR_SLEEP);
         rd(STATUS_OFFSET, {1'b0, STEP_ONE, MODE_NORMAL, pe});
         @(negedge i_clock);
         `CHK("power", pe, o_power_state)
         `CHK("park", i == 2, o_park_req)
         `CHK("low gain", i == 2, o_spindle_low_gain)
      end
      $display("test registers and power done");
      repeat (4) begin
         v = $random(seed);
         @(posedge i_clock);
         {i_serial_data_out, i_serial_data_drive, i_reset_request} <= v[2:0];
         cyc(2);
         @(negedge i_clock);
         `CHK("normal data", v[2], o_serial_data)
         `CHK("normal data enable", ~v[1], o_serial_data_oe_n)
         `CHK("normal reset", v[0], o_reset_out)
         `CHK("normal hall enable", 1'b0, o_hall_oe_n)
      end
      pins(1'b1, 1'b0);
      repeat (8) begin
         v = $random(seed);
         @(posedge i_clock);
         {i_read_write, i_serial_load, sclk_b, i_refclk_pin_level, i_undervoltage_in_a, i_undervoltage_in_b} <= v[5:0];
         cyc(2);
         @(negedge i_clock);
         `CHK("mapped data", v[5] ^ v[4], o_serial_data)
         `CHK("mapped hall", v[3] ^ v[2], o_hall_out)
         `CHK("mapped reset", v[1] ^ v[0], o_reset_out)
      end
      @(posedge i_clock);
      sclk_b <= 1'b0;
      pins(1'b0, 1'b1);
      @(negedge i_clock);
      `CHK("released outputs", 3'h7, {o_hall_oe_n, o_reset_oe_n, o_serial_data_oe_n})
      $display("test pin modes done");
      pins(1'b1, 1'b1);
      for (int k = 0; k < 12; k++) begin
         s = 3'(k % 7 + 1);
         v = $random(seed);
         @(posedge i_clock);
         {i_fll_increment, i_spindle_mask, i_spindle_delay, i_bemf_raw, i_vcm_predriver_a, i_vcm_predriver_f} <= v[5:0];
         cyc(2);
         @(negedge i_clock);
         `CHK("analog step", s, o_analog_observe_out)
         ob = s == 1 ? v[5] : s == 2 ? v[4] : s == 3 ? v[3] : s == 5 ? v[2] : s == 6 ? v[1] : v[0];
         if (s == 4) begin
            gap(n);
            `CHK("divided clock", k > 7 ? 16 : 8, n)
         end else begin
            `CHK("observed bit", ob, o_digital_observe_out)
         end
         if (k == 7) wr(CTRL_OFFSET, 8'h02);
         @(posedge i_clock);
         go <= 1'b1;
         @(posedge i_clock);
         go <= 1'b0;
         cyc(4);
      end
      pins(1'b0, 1'b0);
      pins(1'b1, 1'b1);
      @(negedge i_clock);
      `CHK("entry step", STEP_ONE, o_analog_observe_out)
      pins(1'b0, 1'b0);
      $display("test observation done");
      for (int sl = 0; sl < 2; sl++) begin
         slow <= sl[0];
         wr(CTRL_OFFSET, 8'h1C);
         n = 0;
         while (o_retract_req !== 1'b1 && n < 10) begin
            @(negedge i_clock);
            n++;
         end
         `CHK("drivers during retract", LOW_SIDE_OFF, o_low_side_on)
         n = 0;
         while (o_low_side_on !== LOW_SIDE_ALL && n < 20) begin
            @(negedge i_clock);
            n++;
         end
         `CHK("brake drivers", LOW_SIDE_ALL, o_low_side_on)
         `CHK("retract after brake", 1'b0, o_retract_req)
         wr(CTRL_OFFSET, 8'h18);
         cyc(3);
         `CHK("drivers released", LOW_SIDE_OFF, o_low_side_on)
      end
      $display("test brake done");
      wr(CTRL_OFFSET, 8'h00);
      for (int g = 0; g < 3; g++) begin
         @(posedge i_clock);
         i_bemf_raw <= g != 2;
         if (g == 1) begin
            @(posedge i_clock);
            i_bemf_raw <= 1'b0;
            @(posedge i_clock);
            i_bemf_raw <= 1'b1;
         end
         cyc(6);
         @(negedge i_clock);
         `CHK("hall follows crossing", g != 2, o_hall_out)
      end
      wr(CTRL_OFFSET, 8'h01);
      cyc(6);
      ob = o_hall_out;
      n = 0;
      repeat (6) begin
         @(posedge i_clock);
         i_bemf_raw <= ~i_bemf_raw;
         repeat (8) begin
            @(negedge i_clock);
            if (o_hall_out !== ob) n++;
            ob = o_hall_out;
         end
      end
      `CHK("hall cycle toggles", 2, n)
      $display("test hall done");
      close_out();
   end
endmodule : spindle_combo_test_and_mode_logic_bench
`default_nettype wire
